/* File: rtl/fesl_buf.sv */
// Two-entry valid/ready buffer for transmit code-groups
module fesl_buf #(
   parameter int unsigned W = 5
) (
   // Clock, reset and enable
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic en_i,
   // Fill side
   input wire logic [W-1:0] in_data_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   // Drain side
   output logic [W-1:0] out_data_o,
   output logic out_valid_o,
   input wire logic out_ready_i
);

   logic [W-1:0] mem_q [2];
   logic wr_ptr_q;
   logic rd_ptr_q;
   logic [1:0] count_q;
   logic push;
   logic pop;

   assign in_ready_o = (count_q != 2'h2);
   assign out_valid_o = (count_q != 2'h0);
   assign out_data_o = mem_q[rd_ptr_q];
   assign push = en_i && in_valid_i && in_ready_o;
   assign pop = en_i && out_valid_o && out_ready_i;

   always_ff @(posedge clk_i)
   begin
      if (push)
      begin
         mem_q[wr_ptr_q] <= in_data_i;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (!rstn_i)
      begin
         wr_ptr_q <= 1'b0;
         rd_ptr_q <= 1'b0;
         count_q <= 2'h0;
      end
      else
      begin
         if (push)
         begin
            wr_ptr_q <= ~wr_ptr_q;
         end
         if (pop)
         begin
            rd_ptr_q <= ~rd_ptr_q;
         end
         if (push && !pop)
         begin
            count_q <= count_q + 2'h1;
         end
         else if (pop && !push)
         begin
            count_q <= count_q - 2'h1;
         end
      end
   end

endmodule

/* File: rtl/fesl_line_coding.sv */
// 100 Mb/s scrambler, NRZI/MLT-3 coder, decoder, deserialiser and descrambler

// How it works
// - Transmit key comes from a free-running closed-loop 11-bit LFSR.
// - Each serial transmit NRZ bit is XORed with the current key bit.
// - Scrambler seed is built from the five address straps, unique per device.
// - Scrambled transmit bits pass through an NRZI encoder before line coding.
// - NRZI transitions step the line through zero, positive, zero, negative.
// - Only MLT-3 coded data ever reaches the transmit pair; no binary mode.
// - Signal detect ignores isolated normal or fast link pulses.
// - Received three-level symbols are turned back into an NRZI bit stream.
// - Received NRZI is decoded to NRZ before descrambling.
// - Received bits are deserialised into 5-bit symbols.
// - Descrambler makes the same key and XORs it with each scrambled bit.
// - Lock after 12 consecutive all-ones idles; then emit unaligned 5-bit groups.
// - On lock a 722 us hold timer starts; supervision never stops.
// - 58 bit times of idle before expiry reload the hold timer.
// - Timer expiry drops lock, clears the descrambler state and restarts acquisition.
module fesl_line_coding #(
   parameter int unsigned HOLD_CYCLES = fesl_pkg::HOLD_CYCLES
) (
   // Clock, reset, enable
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic en_i,
   // Straps
   input wire logic [fesl_pkg::STRAP_W-1:0] phy_address_straps_i,
   // Transmit code-groups from the encoder
   input wire logic [fesl_pkg::SYM_W-1:0] tx_group_i,
   input wire logic tx_group_valid_i,
   output logic tx_group_ready_o,
   // Transmit line streams
   output fesl_pkg::fesl_pair_t tx_line_o,
   // Receive line symbols from the equaliser
   input wire fesl_pkg::fesl_pair_t rx_line_i,
   // Receive symbols and status
   output logic [fesl_pkg::SYM_W-1:0] rx_sym_o,
   output logic rx_sym_valid_o,
   output logic rx_locked_o,
   output logic signal_detect_o
);

   localparam logic [fesl_pkg::HOLD_W-1:0] HOLD_LOAD = fesl_pkg::HOLD_W'(HOLD_CYCLES - 1);
   localparam logic [fesl_pkg::RUN_W-1:0] LOCK_RUN = fesl_pkg::RUN_W'(fesl_pkg::LOCK_BITS);
   localparam logic [fesl_pkg::RUN_W-1:0] RELOAD_RUN = fesl_pkg::RUN_W'(fesl_pkg::RELOAD_IDLE_BITS);
   localparam logic [fesl_pkg::SD_W-1:0] SD_GAP = fesl_pkg::SD_W'(fesl_pkg::SD_GAP_MAX);
   localparam logic [fesl_pkg::SD_W-1:0] SD_ON = fesl_pkg::SD_W'(fesl_pkg::SD_ON_BITS);

   // Transmit side
   logic [fesl_pkg::SYM_W-1:0] buf_data;
   logic buf_valid;
   logic buf_take;
   logic [fesl_pkg::SYM_W-1:0] tx_shift_q;
   logic [2:0] tx_cnt_q;
   logic tx_nrz;
   logic [fesl_pkg::LFSR_W-1:0] tx_lfsr_q;
   logic tx_key;
   logic tx_scr;
   logic tx_nrzi_q;
   logic tx_nrzi_d;
   logic [1:0] tx_phase_q;
   logic [1:0] tx_phase_d;
   fesl_pkg::fesl_pair_t tx_line_q;

   // Receive side
   fesl_pkg::fesl_pair_t rx_level;
   fesl_pkg::fesl_pair_t rx_level_q;
   logic rx_active;
   logic rx_nrzi_q;
   logic rx_nrzi_prev_q;
   logic rx_nrz;
   logic rx_bit_ok_q;
   logic [fesl_pkg::SD_W-1:0] sd_gap_q;
   logic [fesl_pkg::SD_W-1:0] sd_run_q;
   logic sd_q;

   // Descrambler
   fesl_pkg::fesl_desc_state_t ds_q;
   fesl_pkg::fesl_desc_state_t ds_d;
   logic [fesl_pkg::LFSR_W-1:0] rx_lfsr_q;
   logic rx_key;
   logic rx_assumed;
   logic rx_ud;
   logic [fesl_pkg::RUN_W-1:0] match_q;
   logic [fesl_pkg::RUN_W-1:0] idle_run_q;
   logic [fesl_pkg::HOLD_W-1:0] hold_q;
   logic hold_expired;
   logic idle_reload;
   logic rx_step;
   logic [fesl_pkg::SYM_W-1:0] rx_shift_q;
   logic [2:0] rx_cnt_q;
   logic [fesl_pkg::SYM_W-1:0] rx_sym_q;
   logic rx_sym_valid_q;

   // Back-pressure reaches the encoder through the buffer's ready
   fesl_buf #(
      .W(fesl_pkg::SYM_W)
   ) u_tx_buf (
      .clk_i(clk_i),
      .rstn_i(rstn_i),
      .en_i(en_i),
      .in_data_i(tx_group_i),
      .in_valid_i(tx_group_valid_i),
      .in_ready_o(tx_group_ready_o),
      .out_data_o(buf_data),
      .out_valid_o(buf_valid),
      .out_ready_i(buf_take)
   );

   assign buf_take = (tx_cnt_q == fesl_pkg::SYM_LAST);

   // Serialiser, MSB first; an empty buffer sends idle so the line never goes quiet
   always_ff @(posedge clk_i)
   begin
      if (!rstn_i)
      begin
         tx_shift_q <= fesl_pkg::IDLE_GROUP;
         tx_cnt_q <= fesl_pkg::SYM_FIRST;
      end
      else if (en_i)
      begin
         if (buf_take)
         begin
            tx_shift_q <= buf_valid ? buf_data : fesl_pkg::IDLE_GROUP;
            tx_cnt_q <= fesl_pkg::SYM_FIRST;
         end
         else
         begin
            tx_shift_q <= {tx_shift_q[fesl_pkg::SYM_W-2:0], 1'b0};
            tx_cnt_q <= tx_cnt_q + 3'h1;
         end
      end
   end

   assign tx_nrz = tx_shift_q[fesl_pkg::SYM_W-1];
   assign tx_key = tx_lfsr_q[fesl_pkg::LFSR_TAP_HI] ^ tx_lfsr_q[fesl_pkg::LFSR_TAP_LO];
   assign tx_scr = tx_nrz ^ tx_key;

   // Seed is loaded in the clocked reset, so the straps are caught there
   always_ff @(posedge clk_i)
   begin
      if (!rstn_i)
      begin
         tx_lfsr_q <= {phy_address_straps_i, fesl_pkg::SEED_FILL};
      end
      else if (en_i)
      begin
         tx_lfsr_q <= {tx_lfsr_q[fesl_pkg::LFSR_W-2:0], tx_key};
      end
   end

   assign tx_nrzi_d = tx_nrzi_q ^ tx_scr;

   always_ff @(posedge clk_i)
   begin
      if (!rstn_i)
      begin
         tx_nrzi_q <= 1'b0;
      end
      else if (en_i)
      begin
         tx_nrzi_q <= tx_nrzi_d;
      end
   end

   // Every NRZI transition steps the three-level phase
   always_comb
   begin
      tx_phase_d = tx_phase_q;
      if (tx_nrzi_d != tx_nrzi_q)
      begin
         tx_phase_d = tx_phase_q + 2'h1;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (!rstn_i)
      begin
         tx_phase_q <= fesl_pkg::PH_ZERO_A;
         tx_line_q <= '0;
      end
      else if (en_i)
      begin
         tx_phase_q <= tx_phase_d;
         tx_line_q.pos <= (tx_phase_d == fesl_pkg::PH_POS);
         tx_line_q.neg <= (tx_phase_d == fesl_pkg::PH_NEG);
      end
   end

   assign tx_line_o = tx_line_q;

   // Both streams high is not a legal level; fold it to zero
   always_comb
   begin
      rx_level = rx_line_i;
      if (rx_line_i.pos && rx_line_i.neg)
      begin
         rx_level = '0;
      end
   end

   assign rx_active = (rx_level != rx_level_q);

   always_ff @(posedge clk_i)
   begin
      if (!rstn_i)
      begin
         rx_level_q <= '0;
         rx_nrzi_q <= 1'b0;
         rx_nrzi_prev_q <= 1'b0;
      end
      else if (en_i)
      begin
         rx_level_q <= rx_level;
         rx_nrzi_q <= rx_nrzi_q ^ rx_active;
         rx_nrzi_prev_q <= rx_nrzi_q;
      end
   end

   assign rx_nrz = rx_nrzi_q ^ rx_nrzi_prev_q;

   // Link pulses are short and sparse, so they never build a long active run
   always_ff @(posedge clk_i)
   begin
      if (!rstn_i)
      begin
         sd_gap_q <= SD_GAP;
         sd_run_q <= '0;
         sd_q <= 1'b0;
      end
      else if (en_i)
      begin
         if (rx_active)
         begin
            sd_gap_q <= '0;
         end
         else if (sd_gap_q != SD_GAP)
         begin
            sd_gap_q <= sd_gap_q + 1'b1;
         end
         if (sd_gap_q == SD_GAP)
         begin
            sd_run_q <= '0;
            sd_q <= 1'b0;
         end
         else if (sd_run_q != SD_ON)
         begin
            sd_run_q <= sd_run_q + 1'b1;
         end
         else
         begin
            sd_q <= 1'b1;
         end
      end
   end

   assign signal_detect_o = sd_q;

   // Decoder output lags the pin by one stage
   always_ff @(posedge clk_i)
   begin
      if (!rstn_i)
      begin
         rx_bit_ok_q <= 1'b0;
      end
      else if (en_i)
      begin
         rx_bit_ok_q <= sd_q;
      end
   end

   assign rx_step = en_i && rx_bit_ok_q;
   assign rx_key = rx_lfsr_q[fesl_pkg::LFSR_TAP_HI] ^ rx_lfsr_q[fesl_pkg::LFSR_TAP_LO];
   assign rx_assumed = ~rx_nrz;
   assign rx_ud = rx_nrz ^ rx_key;
   assign hold_expired = (hold_q == '0);
   assign idle_reload = (idle_run_q == RELOAD_RUN);

   always_comb
   begin
      ds_d = ds_q;
      case (ds_q)
         fesl_pkg::DS_HUNT:
         begin
            if (match_q == LOCK_RUN)
            begin
               ds_d = fesl_pkg::DS_LOCK;
            end
         end
         fesl_pkg::DS_LOCK:
         begin
            if (!rx_bit_ok_q || (hold_expired && !idle_reload))
            begin
               ds_d = fesl_pkg::DS_DROP;
            end
         end
         fesl_pkg::DS_DROP:
         begin
            ds_d = fesl_pkg::DS_HUNT;
         end
         default:
         begin
            ds_d = fesl_pkg::DS_DROP;
         end
      endcase
   end

   always_ff @(posedge clk_i)
   begin
      if (!rstn_i)
      begin
         ds_q <= fesl_pkg::DS_HUNT;
      end
      else if (en_i)
      begin
         ds_q <= ds_d;
      end
   end

   // While hunting, the key is guessed from bits assumed to be idle ones
   always_ff @(posedge clk_i)
   begin
      if (!rstn_i || (en_i && ds_q == fesl_pkg::DS_DROP))
      begin
         rx_lfsr_q <= '0;
         match_q <= '0;
      end
      else if (rx_step)
      begin
         if (ds_q == fesl_pkg::DS_HUNT)
         begin
            rx_lfsr_q <= {rx_lfsr_q[fesl_pkg::LFSR_W-2:0], rx_assumed};
            if (rx_key != rx_assumed)
            begin
               match_q <= '0;
            end
            else if (match_q != LOCK_RUN)
            begin
               match_q <= match_q + 1'b1;
            end
         end
         else
         begin
            rx_lfsr_q <= {rx_lfsr_q[fesl_pkg::LFSR_W-2:0], rx_key};
            match_q <= '0;
         end
      end
   end

   // Idle run and hold timer supervise lock for as long as it lasts
   always_ff @(posedge clk_i)
   begin
      if (!rstn_i || (en_i && ds_q != fesl_pkg::DS_LOCK))
      begin
         idle_run_q <= '0;
         hold_q <= HOLD_LOAD;
      end
      else if (en_i)
      begin
         if (idle_reload)
         begin
            hold_q <= HOLD_LOAD;
            idle_run_q <= '0;
         end
         else
         begin
            if (!hold_expired)
            begin
               hold_q <= hold_q - 1'b1;
            end
            if (rx_step)
            begin
               idle_run_q <= rx_ud ? idle_run_q + 1'b1 : '0;
            end
         end
      end
   end

   assign rx_locked_o = (ds_q == fesl_pkg::DS_LOCK);

   // Groups are unaligned; alignment to J/K happens further up
   always_ff @(posedge clk_i)
   begin
      if (!rstn_i || (en_i && ds_q != fesl_pkg::DS_LOCK))
      begin
         rx_shift_q <= '0;
         rx_cnt_q <= fesl_pkg::SYM_FIRST;
         rx_sym_q <= '0;
         rx_sym_valid_q <= 1'b0;
      end
      else if (en_i)
      begin
         rx_sym_valid_q <= 1'b0;
         if (rx_step)
         begin
            rx_shift_q <= {rx_shift_q[fesl_pkg::SYM_W-2:0], rx_ud};
            if (rx_cnt_q == fesl_pkg::SYM_LAST)
            begin
               rx_cnt_q <= fesl_pkg::SYM_FIRST;
               rx_sym_q <= {rx_shift_q[fesl_pkg::SYM_W-2:0], rx_ud};
               rx_sym_valid_q <= 1'b1;
            end
            else
            begin
               rx_cnt_q <= rx_cnt_q + 3'h1;
            end
         end
      end
   end

   assign rx_sym_o = rx_sym_q;
   assign rx_sym_valid_o = rx_sym_valid_q;

endmodule

/* File: rtl/fesl_pkg.sv */
// Constants and types shared by the 100 Mb/s scramble and line coding path
package fesl_pkg;

   // Symbol and scrambler geometry
   localparam int unsigned SYM_W = 5;
   localparam int unsigned LFSR_W = 11;
   localparam int unsigned LFSR_TAP_HI = 10;
   localparam int unsigned LFSR_TAP_LO = 8;
   localparam int unsigned STRAP_W = 5;
   localparam logic [5:0] SEED_FILL = 6'h2B;
   localparam logic [4:0] IDLE_GROUP = 5'h1F;
   localparam logic [2:0] SYM_LAST = 3'h4;
   localparam logic [2:0] SYM_FIRST = 3'h0;

   // Lock acquisition and supervision
   localparam int unsigned LOCK_IDLES = 12;
   localparam int unsigned LOCK_BITS = LOCK_IDLES * SYM_W;
   localparam int unsigned RELOAD_IDLE_BITS = 58;
   localparam int unsigned RUN_W = 7;

   // Hold timer
   localparam int unsigned CLK_FREQ_MHZ = 50;
   localparam int unsigned HOLD_TIME_US = 722;
   localparam int unsigned HOLD_CYCLES = HOLD_TIME_US * CLK_FREQ_MHZ;
   localparam int unsigned HOLD_W = 16;

   // Signal detect
   localparam int unsigned SD_GAP_MAX = 32;
   localparam int unsigned SD_ON_BITS = 256;
   localparam int unsigned SD_W = 9;

   // Transmit MLT-3 phases
   localparam logic [1:0] PH_ZERO_A = 2'h0;
   localparam logic [1:0] PH_POS = 2'h1;
   localparam logic [1:0] PH_ZERO_B = 2'h2;
   localparam logic [1:0] PH_NEG = 2'h3;

   // Two binary line streams forming the three-level signal
   typedef struct packed {
      logic pos;
      logic neg;
   } fesl_pair_t;

   typedef enum logic [2:0] {
      DS_HUNT = 3'b001,
      DS_LOCK = 3'b010,
      DS_DROP = 3'b100
   } fesl_desc_state_t;

endpackage

/* File: tb/fesl_line_coding_chk.sv */
// Port checker for the scramble and line coding block
module fesl_line_coding_chk #(
   parameter int unsigned HOLD_CYCLES = 200
) (
   // Clock and control
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic en_i,
   input wire logic [4:0] phy_address_straps_i,
   // Transmit side
   input wire logic [4:0] tx_group_i,
   input wire logic tx_group_valid_i,
   input wire logic tx_group_ready_o,
   input wire fesl_pkg::fesl_pair_t tx_line_o,
   // Receive side
   input wire fesl_pkg::fesl_pair_t rx_line_i,
   input wire logic [4:0] rx_sym_o,
   input wire logic rx_sym_valid_o,
   input wire logic rx_locked_o,
   input wire logic signal_detect_o
);
   logic last_pos_q;
   logic [3:0] run_q;
   logic [15:0] hold_q;
   logic [5:0] quiet_q;
   fesl_pkg::fesl_pair_t prev_q;
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rstn_i);
   always_ff @(posedge clk_i)
   begin
      if (!rstn_i)
         last_pos_q <= 1'b0;
      else if (tx_line_o.pos || tx_line_o.neg)
         last_pos_q <= tx_line_o.pos;
   end
   // Hold age restarts only after twelve idle symbols, so it lags the real reload
   always_ff @(posedge clk_i)
   begin
      if (!rstn_i || !rx_locked_o || run_q == 4'hC)
         run_q <= 4'h0;
      else if (rx_sym_valid_o)
         run_q <= (rx_sym_o == 5'h1F) ? run_q + 4'h1 : 4'h0;
      if (!rstn_i || !rx_locked_o || run_q == 4'hC)
         hold_q <= 16'h0;
      else
         hold_q <= hold_q + 16'h1;
   end
   always_ff @(posedge clk_i)
   begin
      prev_q <= rx_line_i;
      if (!rstn_i || rx_line_i != prev_q)
         quiet_q <= 6'h0;
      else if (quiet_q != 6'h3F)
         quiet_q <= quiet_q + 6'h1;
   end
   chk_one_level: assert property (!(tx_line_o.pos && tx_line_o.neg))
      else $error("both line streams high");
   chk_pos_via_zero: assert property (tx_line_o.pos |=> !tx_line_o.neg)
      else $error("line jumped from plus to minus");
   chk_pos_alternates: assert property ($rose(tx_line_o.pos) |-> !last_pos_q)
      else $error("two plus levels in a row");
   chk_neg_alternates: assert property ($rose(tx_line_o.neg) |-> last_pos_q)
      else $error("two minus levels in a row");
   chk_first_symbol: assert property ($rose(rx_locked_o) |-> ##5 rx_sym_valid_o)
      else $error("first symbol not five bits after lock");
   chk_symbol_spacing: assert property (rx_sym_valid_o |=> !rx_sym_valid_o [*4])
      else $error("symbols closer than five bits");
   chk_lock_needs_sd: assert property ($rose(rx_locked_o) |-> $past(signal_detect_o, 60))
      else $error("lock without sustained signal detect");
   chk_relock_delay: assert property ($fell(rx_locked_o) |=> !rx_locked_o [*8])
      else $error("lock regained without hunting");
   chk_hold_bound: assert property (rx_locked_o |-> hold_q < HOLD_CYCLES + 80)
      else $error("lock outlived the hold period");
   chk_quiet_no_sd: assert property (quiet_q >= 6'h28 |-> !signal_detect_o)
      else $error("signal detect on a quiet line");
   cov_lock: cover property ($rose(rx_locked_o));
   cov_drop: cover property ($fell(rx_locked_o));
   cov_sd: cover property ($rose(signal_detect_o));
endmodule

bind fesl_line_coding fesl_line_coding_chk #(.HOLD_CYCLES(HOLD_CYCLES)) u_chk (
   .clk_i(clk_i), .rstn_i(rstn_i), .en_i(en_i), .phy_address_straps_i(phy_address_straps_i),
   .tx_group_i(tx_group_i), .tx_group_valid_i(tx_group_valid_i), .tx_group_ready_o(tx_group_ready_o),
   .tx_line_o(tx_line_o), .rx_line_i(rx_line_i), .rx_sym_o(rx_sym_o), .rx_sym_valid_o(rx_sym_valid_o),
   .rx_locked_o(rx_locked_o), .signal_detect_o(signal_detect_o)
);

/* File: tb/fesl_partner.sv */
// Link partner model: echoes the line, stays silent or sends link pulses
module fesl_partner (
   // Clock and mode
   input wire logic clk_i,
   input wire logic [1:0] mode_i,
   // Line
   input wire fesl_pkg::fesl_pair_t tx_line_i,
   output fesl_pkg::fesl_pair_t rx_line_o
);
   timeunit 1ns;
   timeprecision 1ns;
   int cnt = 0;
   initial rx_line_o = '0;
   // Echo keys identically to the device, so it stands for a same-polynomial partner
   always @(posedge clk_i)
   begin
      cnt <= (cnt == 99) ? 0 : cnt + 1;
      case (mode_i)
         2'h0: rx_line_o <= tx_line_i;
         2'h2: rx_line_o <= '{pos: (cnt < 2), neg: 1'b0};
         default: rx_line_o <= '0;
      endcase
   end
endmodule

/* File: tb/test_fast_ethernet_scramble_line_coding.sv */
// Self-checking bench for the scramble and line coding block
module test_fast_ethernet_scramble_line_coding;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int unsigned HOLD = 400;
   logic clk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic [4:0] straps = 5'h00;
   logic [4:0] tx_group = 5'h1F;
   logic tx_valid = 1'b0;
   logic [1:0] mode = 2'h0;
   logic tx_ready, sym_valid, locked, sd;
   logic [4:0] sym;
   fesl_pkg::fesl_pair_t tx_line, rx_line, prev_line;
   int bad_count = 0;
   int n_tests = 0;
   int cycles = 0;
   int ok, hit, ones;
   logic rec = 1'b0;
   logic ready_low = 1'b0;
   logic [31:0] rnd = 32'hDE65;
   logic txb[$];
   logic rxb[$];
   logic exb[$];
   fesl_line_coding #(.HOLD_CYCLES(HOLD)) uut (
      .clk_i(clk_i), .rstn_i(rstn_i), .en_i(1'b1), .phy_address_straps_i(straps),
      .tx_group_i(tx_group), .tx_group_valid_i(tx_valid), .tx_group_ready_o(tx_ready),
      .tx_line_o(tx_line), .rx_line_i(rx_line), .rx_sym_o(sym), .rx_sym_valid_o(sym_valid),
      .rx_locked_o(locked), .signal_detect_o(sd)
   );
   fesl_partner partner (.clk_i(clk_i), .mode_i(mode), .tx_line_i(tx_line), .rx_line_o(rx_line));
   initial forever #10 clk_i = ~clk_i;
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   always @(posedge clk_i)
   begin
      cycles++;
      if (cycles == 40000)
      begin
         bad_count++;
         close_out();
      end
   end
   // Negedge sampling sees settled outputs and each one-cycle symbol once
   always @(negedge clk_i)
   begin
      if (rec)
         txb.push_back(tx_line != prev_line);
      prev_line = tx_line;
      if (sym_valid === 1'b1)
         for (int i = 4; i >= 0; i--)
            rxb.push_back(sym[i]);
      if (tx_ready === 1'b0)
         ready_low = 1'b1;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   function automatic logic [31:0] xs(input logic [31:0] v);
      logic [31:0] x;
      x = v ^ (v << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   task automatic do_reset(input logic [4:0] s);
      @(posedge clk_i);
      #1;
      rstn_i = 1'b0;
      straps = s;
      repeat (20) @(posedge clk_i);
      #1;
      check(tx_line, 2'h0);
      check({locked, sd, sym_valid}, 3'h0);
      rstn_i = 1'b1;
      txb.delete();
      rec = 1'b1;
      repeat (40) @(posedge clk_i);
   endtask
   // Idle groups are all ones, so each line step must equal the inverted key
   task automatic seed_check(input logic [4:0] s);
      logic [10:0] l;
      logic k[$];
      int good;
      l = {s, 6'h2B};
      hit = 0;
      for (int i = 0; i < 40; i++)
      begin
         k.push_back(~(l[10] ^ l[8]));
         l = {l[9:0], l[10] ^ l[8]};
      end
      for (int off = 0; off < 4; off++)
      begin
         good = 1;
         for (int j = 0; j < 30; j++)
            if (txb[j + off] !== k[j])
               good = 0;
         hit |= good;
      end
      check(hit, 1);
   endtask
   // Ready is judged between edges, except when a call starts in the step of the edge that updates it
   task automatic send(input logic [4:0] g);
      tx_group = g;
      tx_valid = 1'b1;
      while (tx_ready !== 1'b1)
      begin
         @(posedge clk_i);
         #1;
      end
      @(posedge clk_i);
      #1;
   endtask
   task automatic wait_lock(input logic want, input int lim);
      for (int n = 0; n < lim && locked !== want; n++)
      begin
         @(posedge clk_i);
         #1;
      end
      check(locked, want);
   endtask
   initial
   begin
      do_reset(5'h13);
      seed_check(5'h13);
      do_reset(5'h0C);
      seed_check(5'h0C);
      rec = 1'b0;
      wait_lock(1'b1, 2000);
      check(sd, 1);
      rxb.delete();
      repeat (3 * HOLD) @(posedge clk_i);
      #1;
      check(locked, 1);
      ones = 0;
      foreach (rxb[i])
         ones += rxb[i];
      check(ones, rxb.size());
      check(rxb.size() >= 3 * HOLD - 10, 1);
      rxb.delete();
      for (int i = 0; i < 40; i++)
      begin
         rnd = xs(rnd);
         send(rnd[4:0]);
         for (int b = 4; b >= 0; b--)
            exb.push_back(rnd[b]);
      end
      tx_valid = 1'b0;
      check(ready_low, 1);
      repeat (150) @(posedge clk_i);
      hit = 0;
      for (int o = 0; o + exb.size() <= rxb.size(); o++)
      begin
         ok = 1;
         foreach (exb[j])
            if (rxb[o + j] !== exb[j])
               ok = 0;
         hit |= ok;
      end
      check(hit, 1);
      for (int i = 0; i < 120; i++)
         send(5'h00);
      tx_valid = 1'b0;
      check(locked, 0);
      wait_lock(1'b1, 2000);
      mode = 2'h1;
      repeat (100) @(posedge clk_i);
      #1;
      check({sd, locked}, 2'h0);
      mode = 2'h2;
      for (int i = 0; i < 10; i++)
      begin
         repeat (100) @(posedge clk_i);
         #1;
         check(sd, 0);
      end
      close_out();
   end
endmodule
